// >>> core/aut_issue_timer.sv
// Address-unit issue timing sequencer
// How it works
// - Break zero: next instruction starts without waiting.
// - Positive break: flush, wait that many cycles.
// - Negative break: restart magnitude cycles before end.
// - Write drain stalls seven, plus two for a second operand.
// - Locked bit access adds three cycles.
// - Queue delay only in pipelined mode, integer or floating.
// - No break: hide address time when possible.
// - After break: exposed is address plus code.
// - Transfer zero integer; else send, read, execute.
// - Pipelined: group A free, group B max.
// - Size code zero standard, one long.
// - Four branch outcomes; mispredicted ones break two.
// - Execution time sums four terms.
// - Total adds dependency and storage delays.
// - Completion covers done handling and result read.
`timescale 1ns/1ns
`default_nettype none
`include "aut_map.svh"

module aut_issue_timer (
    // Clock and reset
    input  wire logic                            core_clk_i,
    input  wire logic                            arst_n_i,
    // Instruction offer
    input  wire logic                            instr_valid_i,
    input  wire aut_pkg::aut_instr_type          instr_i,
    output logic                                 instr_ready_o,
    // Coprocessor queue and mode
    input  wire aut_pkg::aut_queue_type          queue_i,
    input  wire logic                            pipelined_i,
    // Timing results
    output logic [`AUT_SUM_W-1:0]                te_o,
    output logic [`AUT_SUM_W-1:0]                teff_o,
    output logic [`AUT_SUM_W-1:0]                tdpr_o,
    output logic [`AUT_SUM_W-1:0]                exposed_o,
    output logic [`AUT_SUM_W-1:0]                tfit_o,
    output logic [`AUT_SUM_W-1:0]                stall_o,
    output logic signed [`AUT_BREAK_W-1:0]       break_o,
    // Pipeline events
    output logic                                 au_start_o,
    output logic                                 done_o,
    output logic                                 busy_o
);

    // Terms for the offered instruction
    logic [`AUT_SUM_W-1:0]              tdpr_c;
    logic [`AUT_SUM_W-1:0]              exposed_c;
    logic [`AUT_SUM_W-1:0]              tfit_c;
    logic [`AUT_SUM_W-1:0]              stall_c;
    logic                               broke_c;
    logic signed [`AUT_BREAK_W-1:0]     k_c;
    logic [`AUT_SUM_W-1:0]              teu_c;      // Widened execution time
    logic [`AUT_SUM_W-1:0]              te_c;       // Pipeline execution time

    // Previous instruction memory
    logic [`AUT_TIME_W-1:0]             prev_teu_r;
    logic [`AUT_SUM_W-1:0]              prev_tfit_r;
    logic                               prev_broke_r;
    logic signed [`AUT_BREAK_W-1:0]     prev_k_r;

    // Sequencer
    aut_pkg::aut_state_type             state_r;
    aut_pkg::aut_state_type             state_nxt;
    logic [`AUT_SUM_W-1:0]              cnt_r;      // Cycles left in state
    logic [`AUT_SUM_W-1:0]              teu_r;      // Execution time held
    logic [`AUT_SUM_W-1:0]              mag;        // Break magnitude
    logic                               started_r;  // Early restart seen
    logic                               accept;
    logic                               exec_last;
    logic                               early;

    // Term calculator
    aut_term_calc u_terms (
        .instr_i      (instr_i),
        .queue_i      (queue_i),
        .pipelined_i  (pipelined_i),
        .prev_teu_i   (prev_teu_r),
        .prev_tfit_i  (prev_tfit_r),
        .prev_broke_i (prev_broke_r),
        .prev_k_i     (prev_k_r),
        .tdpr_o       (tdpr_c),
        .exposed_o    (exposed_c),
        .tfit_o       (tfit_c),
        .stall_o      (stall_c),
        .broke_o      (broke_c),
        .k_o          (k_c)
    );

    // Sum of the four terms, all in cycles
    always_comb begin
        teu_c = {{(`AUT_SUM_W-`AUT_TIME_W){1'b0}}, instr_i.execution_unit_time};
        te_c  = tdpr_c + exposed_c + teu_c + tfit_c;
    end

    // Handshake and phase decodes
    always_comb begin
        accept    = instr_valid_i && (state_r == aut_pkg::aut_st_idle);
        exec_last = (state_r == aut_pkg::aut_st_exec) && (cnt_r == 12'h001);
        mag       = (break_o < 0) ? `AUT_SUM_W'(-break_o) : `AUT_SUM_W'(break_o);
        // Restart point reached, or break longer than the instruction;
        // one cycle of lead, since the release pulse is registered
        early     = (state_r == aut_pkg::aut_st_exec) && !started_r &&
                    (break_o < 0) && (cnt_r <= mag + 12'h001);
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            aut_pkg::aut_st_idle: begin
                if (accept) begin
                    state_nxt = (stall_c != '0) ? aut_pkg::aut_st_wait
                                                : aut_pkg::aut_st_exec;
                end
            end
            aut_pkg::aut_st_wait: begin
                if (cnt_r == 12'h001) begin
                    state_nxt = aut_pkg::aut_st_exec;
                end
            end
            aut_pkg::aut_st_exec: begin
                if (cnt_r == 12'h001) begin
                    // Flush only on a positive break
                    state_nxt = (break_o > 0) ? aut_pkg::aut_st_flush
                                              : aut_pkg::aut_st_idle;
                end
            end
            aut_pkg::aut_st_flush: begin
                if (cnt_r == 12'h001) begin
                    state_nxt = aut_pkg::aut_st_idle;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= aut_pkg::aut_st_idle;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle counter, reloaded on each phase entry
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
        end else if (accept) begin
            // An empty execute still takes one cycle
            cnt_r <= (stall_c != '0) ? stall_c : ((te_c == '0) ? 12'h001 : te_c);
        end else if (state_r == aut_pkg::aut_st_wait && cnt_r == 12'h001) begin
            cnt_r <= (te_o == '0) ? 12'h001 : te_o;
        end else if (exec_last) begin
            cnt_r <= mag;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 12'h001;
        end
    end

    // Results captured on acceptance
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            te_o      <= '0;
            teff_o    <= '0;
            tdpr_o    <= '0;
            exposed_o <= '0;
            tfit_o    <= '0;
            stall_o   <= '0;
            break_o   <= '0;
            teu_r     <= '0;
        end else if (accept) begin
            te_o      <= te_c;
            teff_o    <= te_c + `AUT_SUM_W'(instr_i.t_dep)
                       + `AUT_SUM_W'(instr_i.t_storage);
            tdpr_o    <= tdpr_c;
            exposed_o <= exposed_c;
            tfit_o    <= tfit_c;
            stall_o   <= stall_c;
            break_o   <= broke_c ? k_c : '0;
            teu_r     <= teu_c;
        end
    end

    // Previous-instruction memory for hiding decisions
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_teu_r   <= '0;
            prev_tfit_r  <= '0;
            prev_broke_r <= 1'b0;
            prev_k_r     <= '0;
        end else if (accept) begin
            prev_teu_r   <= instr_i.execution_unit_time;
            prev_tfit_r  <= tfit_c;
            prev_broke_r <= broke_c;
            prev_k_r     <= k_c;
        end
    end

    // Address-unit release pulse
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            au_start_o <= 1'b0;
            started_r  <= 1'b0;
        end else begin
            if (accept) begin
                started_r <= 1'b0;
            end else if (early) begin
                started_r <= 1'b1;
            end
            if (early) begin
                au_start_o <= 1'b1;
            end else if (exec_last && break_o == '0) begin
                au_start_o <= 1'b1;
            end else if (state_r == aut_pkg::aut_st_flush && cnt_r == 12'h001) begin
                au_start_o <= 1'b1;
            end else begin
                au_start_o <= 1'b0;
            end
        end
    end

    // Handshake and status flags
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instr_ready_o <= 1'b1;
            done_o        <= 1'b0;
            busy_o        <= 1'b0;
        end else begin
            instr_ready_o <= (state_nxt == aut_pkg::aut_st_idle);
            busy_o        <= (state_nxt != aut_pkg::aut_st_idle);
            done_o        <= exec_last;
        end
    end

    // Checks on the sequencer and its arithmetic
    a_te_sum: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        te_o == tdpr_o + exposed_o + teu_r + tfit_o)
        else $error("execution time is not the sum of its terms");

    a_teff_total: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept |=> teff_o == te_o + $past(instr_i.t_dep)
                   + $past(instr_i.t_storage))
        else $error("total time lost a delay term");

    a_zero_break: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        exec_last && break_o == '0 |=> au_start_o && instr_ready_o)
        else $error("break zero did not release at once");

    a_flush_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        exec_last && break_o == 8'sh02 |=> !au_start_o ##1 !au_start_o ##1 au_start_o)
        else $error("flush of two did not wait two cycles");

    a_early_start: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        state_r == aut_pkg::aut_st_exec && break_o == -8'sd1 && cnt_r == 12'h002
        && !started_r |=> au_start_o)
        else $error("negative break missed its restart");

    a_write_drain: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && instr_i.wait_writes && !instr_i.second_operand && !instr_i.interlocked
        |=> (state_r == aut_pkg::aut_st_wait) [*7] ##1 state_r == aut_pkg::aut_st_exec)
        else $error("write drain not seven cycles");

    a_rmw_extra: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && instr_i.wait_writes && instr_i.second_operand && instr_i.interlocked
        |=> stall_o == 12'h00c)
        else $error("locked access stall wrong");

    a_queue_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && !pipelined_i |=> tdpr_o == '0)
        else $error("queue delay outside pipelined mode");

    a_hidden_time: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && !prev_broke_r && `AUT_SUM_W'(instr_i.address_unit_time)
        <= `AUT_SUM_W'(prev_teu_r) + prev_tfit_r |=> exposed_o == '0)
        else $error("hideable address time exposed");

    a_integer_xfer: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && !instr_i.is_float |=> tfit_o == '0)
        else $error("integer instruction has transfer time");

    a_group_a_free: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && pipelined_i && instr_i.is_float
        && instr_i.group == aut_pkg::aut_group_a |=> tfit_o == '0)
        else $error("group A added transfer time");

    a_mispredict: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        accept && instr_i.is_branch && instr_i.branch == aut_pkg::taken_predicted_wrong
        |=> break_o == 8'sh02)
        else $error("mispredicted branch did not break two");

    // Release and completion are single-cycle events
    a_start_single: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        au_start_o |=> !au_start_o)
        else $error("address unit release longer than one cycle");

    a_done_single: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        done_o |=> !done_o)
        else $error("done pulse longer than one cycle");

endmodule : aut_issue_timer
`default_nettype wire

// >>> common/aut_map.svh
// Constants for the address-unit issue timing block
`ifndef AUT_MAP_SVH
`define AUT_MAP_SVH

// Field widths, in bits
`define AUT_TIME_W        8
`define AUT_SUM_W         12
`define AUT_BREAK_W       8

// Pending-write drain, in processor cycles
`define AUT_WAIT_FIRST_MIN 12'h006
`define AUT_WAIT_FIRST_MAX 12'h007
`define AUT_WAIT_SECOND    12'h002

// Locked read-modify-write extra, in cycles
`define AUT_RMW_EXTRA      12'h003

// Break code forced by a mispredicted branch
`define AUT_MISPRED_BREAK  8'sh02

// Floating operand size codes
`define AUT_SIZE_STD       1'b0
`define AUT_SIZE_LONG      1'b1

`endif

// >>> common/aut_pkg.sv
// Types for the address-unit issue timing block
`include "aut_map.svh"

package aut_pkg;

    // Floating operand size, standard or long
    typedef enum logic {
        aut_size_std  = `AUT_SIZE_STD,
        aut_size_long = `AUT_SIZE_LONG
    } aut_size_type;

    // Coprocessor instruction group
    typedef enum logic {
        aut_group_a = 1'b0,
        aut_group_b = 1'b1
    } aut_group_type;

    // Conditional branch outcome
    typedef enum logic [1:0] {
        taken_predicted_right     = 2'h0,
        taken_predicted_wrong     = 2'h1,
        not_taken_predicted_right = 2'h2,
        not_taken_predicted_wrong = 2'h3
    } aut_branch_type;

    // Sequencer states
    typedef enum logic [1:0] {
        aut_st_idle  = 2'h0,
        aut_st_wait  = 2'h1,
        aut_st_exec  = 2'h2,
        aut_st_flush = 2'h3
    } aut_state_type;

    // One instruction descriptor
    typedef struct packed {
        logic [`AUT_TIME_W-1:0]          address_unit_time;
        logic [`AUT_TIME_W-1:0]          execution_unit_time;
        logic                            has_break;
        logic signed [`AUT_BREAK_W-1:0]  break_code;
        logic                            is_branch;
        aut_branch_type                  branch;
        logic                            wait_writes;
        logic                            second_operand;
        logic                            interlocked;
        logic                            is_float;
        aut_group_type                   group;
        aut_size_type                    size;
        logic                            float_mem_break;
        logic [`AUT_TIME_W-1:0]          t_send;
        logic [`AUT_TIME_W-1:0]          t_complete;
        logic [`AUT_TIME_W-1:0]          t_fpu;
        logic [`AUT_TIME_W-1:0]          t_dep;
        logic [`AUT_TIME_W-1:0]          t_storage;
    } aut_instr_type;

    // Coprocessor queue state
    typedef struct packed {
        logic                   full;
        logic [`AUT_TIME_W-1:0] all_time;
        logic [`AUT_TIME_W-1:0] first_time;
    } aut_queue_type;

endpackage : aut_pkg

// >>> core/aut_term_calc.sv
// Per-instruction timing terms, combinational
`timescale 1ns/1ns
`default_nettype none
`include "aut_map.svh"

module aut_term_calc (
    // Current instruction and queue
    input  wire aut_pkg::aut_instr_type             instr_i,
    input  wire aut_pkg::aut_queue_type             queue_i,
    input  wire logic                               pipelined_i,
    // State left by the previous instruction
    input  wire logic [`AUT_TIME_W-1:0]             prev_teu_i,
    input  wire logic [`AUT_SUM_W-1:0]              prev_tfit_i,
    input  wire logic                               prev_broke_i,
    input  wire logic signed [`AUT_BREAK_W-1:0]     prev_k_i,
    // Terms
    output logic [`AUT_SUM_W-1:0]                   tdpr_o,
    output logic [`AUT_SUM_W-1:0]                   exposed_o,
    output logic [`AUT_SUM_W-1:0]                   tfit_o,
    output logic [`AUT_SUM_W-1:0]                   stall_o,
    output logic                                    broke_o,
    output logic signed [`AUT_BREAK_W-1:0]          k_o
);

    logic [`AUT_SUM_W-1:0]        tau;      // Widened address-unit time
    logic [`AUT_SUM_W-1:0]        hide;     // Previous time that can hide it
    logic signed [`AUT_SUM_W:0]   tau_k;    // Address time plus break code

    // Widen operands once
    always_comb begin
        tau   = {{(`AUT_SUM_W-`AUT_TIME_W){1'b0}}, instr_i.address_unit_time};
        hide  = {{(`AUT_SUM_W-`AUT_TIME_W){1'b0}}, prev_teu_i} + prev_tfit_i;
        tau_k = $signed({1'b0, tau}) + (`AUT_SUM_W+1)'(prev_k_i);
    end

    // Coprocessor transfer time
    always_comb begin
        if (!instr_i.is_float) begin
            tfit_o = '0;
        end else if (!pipelined_i) begin
            tfit_o = `AUT_SUM_W'(instr_i.t_send) + `AUT_SUM_W'(instr_i.t_complete)
                   + `AUT_SUM_W'(instr_i.t_fpu);
        end else if (instr_i.group == aut_pkg::aut_group_a) begin
            tfit_o = '0;
        end else begin
            // Larger of queue drain and operand send, then completion
            tfit_o = `AUT_SUM_W'((queue_i.all_time > instr_i.t_send) ?
                     queue_i.all_time : instr_i.t_send)
                   + `AUT_SUM_W'(instr_i.t_complete);
        end
    end

    // Pre-execution delay, only in pipelined mode
    always_comb begin
        if (!pipelined_i) begin
            tdpr_o = '0;
        end else if (!instr_i.is_float) begin
            tdpr_o = `AUT_SUM_W'(queue_i.all_time);
        end else if (queue_i.full) begin
            tdpr_o = `AUT_SUM_W'(queue_i.first_time);
        end else begin
            tdpr_o = '0;
        end
    end

    // Address-unit time that cannot be hidden
    always_comb begin
        if (!prev_broke_i) begin
            exposed_o = (tau <= hide) ? '0 : tau - `AUT_SUM_W'(prev_teu_i);
        end else begin
            exposed_o = (tau_k > 0) ? tau_k[`AUT_SUM_W-1:0] : '0;
        end
    end

    // Pending-write drain, worst case, plus locked access
    always_comb begin
        stall_o = '0;
        if (instr_i.wait_writes) begin
            stall_o = `AUT_WAIT_FIRST_MAX
                    + (instr_i.second_operand ? `AUT_WAIT_SECOND : '0);
            if (instr_i.interlocked) begin
                stall_o = stall_o + `AUT_RMW_EXTRA;
            end
        end
    end

    // Break this instruction leaves for the next one
    always_comb begin
        broke_o = instr_i.has_break;
        k_o     = instr_i.break_code;
        if (instr_i.is_branch && (instr_i.branch == aut_pkg::taken_predicted_wrong ||
            instr_i.branch == aut_pkg::not_taken_predicted_wrong)) begin
            broke_o = 1'b1;
            k_o     = `AUT_MISPRED_BREAK;
        end else if (instr_i.is_float && instr_i.float_mem_break) begin
            // Floating store releases the address unit 1 + I early
            broke_o = 1'b1;
            k_o     = (instr_i.size == aut_pkg::aut_size_long) ? -8'sd2 : -8'sd1;
        end
    end

endmodule : aut_term_calc
`default_nettype wire

// >>> bench/aut_fpu_model.sv
// Coprocessor queue model facing the issue timer
`timescale 1ns/1ns
`default_nettype none
module aut_fpu_model (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    // Queue load from the bench
    input  wire logic                  load_i,
    input  wire aut_pkg::aut_queue_type cfg_i,
    // Queue state seen by the timer
    output var aut_pkg::aut_queue_type queue_o
);
    // Queue empty after reset; drain times set how slowly it answers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            queue_o <= '0;
        end else if (load_i) begin
            queue_o <= cfg_i; // Held until the next load
        end
    end
endmodule : aut_fpu_model
`default_nettype wire

// >>> bench/address_unit_issue_timing_tb_top.sv
// Self-checking bench for the address-unit issue timer
`timescale 1ns/1ns
`default_nettype none
`include "aut_map.svh"
module address_unit_issue_timing_tb_top;
    // Stimulus and observed signals
    logic core_clk_i, arst_n_i, instr_valid_i, pipelined_i, q_load;
    logic instr_ready_o, au_start_o, done_o, busy_o;
    aut_pkg::aut_instr_type d, instr_i;
    aut_pkg::aut_queue_type q_cfg, queue_w;
    logic [`AUT_SUM_W-1:0] te_o, teff_o, tdpr_o, exposed_o, tfit_o, stall_o;
    logic signed [`AUT_BREAK_W-1:0] break_o;
    // Counters, and the previous instruction as the bench sees it
    int mismatches, compares, p_teu, p_tfit, p_k;
    logic p_brk;

    // Processor clock, 100 ns period
    initial begin
        core_clk_i = 1'h0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    aut_issue_timer dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
        .queue_i(queue_w), .pipelined_i(pipelined_i), .te_o(te_o), .teff_o(teff_o),
        .tdpr_o(tdpr_o), .exposed_o(exposed_o), .tfit_o(tfit_o), .stall_o(stall_o),
        .break_o(break_o), .au_start_o(au_start_o), .done_o(done_o), .busy_o(busy_o));

    // Far-side queue
    aut_fpu_model fpu (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .load_i(q_load),
        .cfg_i(q_cfg), .queue_o(queue_w));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Descriptor with only the two stage times set
    function automatic aut_pkg::aut_instr_type mk(input int au, input int eu);
        mk = '0;
        mk.address_unit_time = au[7:0];
        mk.execution_unit_time = eu[7:0];
    endfunction : mk

    // Offer one instruction, predict every term, then time the events
    task automatic run(input logic pm, input aut_pkg::aut_queue_type q);
        int st, dp, fi, ex, te, k, n, ac, dc, s;
        logic mis, brk;
        mis = d.is_branch && (d.branch == aut_pkg::taken_predicted_wrong ||
              d.branch == aut_pkg::not_taken_predicted_wrong);
        k = mis ? 2 : d.float_mem_break ? -1 - int'(d.size) : d.has_break ? int'(d.break_code) : 0;
        brk = mis | d.float_mem_break | d.has_break;
        st = d.wait_writes ? 7 + 2 * d.second_operand + 3 * d.interlocked : 0;
        dp = !pm ? 0 : !d.is_float ? q.all_time : q.full ? q.first_time : 0;
        s = (q.all_time > d.t_send) ? q.all_time : d.t_send;
        fi = !d.is_float ? 0 : !pm ? d.t_send + d.t_complete + d.t_fpu
           : (d.group == aut_pkg::aut_group_a) ? 0 : s + d.t_complete;
        s = d.address_unit_time;
        // Hidden or exposed address-unit time
        if (p_brk) begin
            ex = (s + p_k > 0) ? s + p_k : 0;
        end else begin
            ex = (s <= p_teu + p_tfit) ? 0 : s - p_teu;
        end
        te = dp + ex + d.execution_unit_time + fi;
        // Queue loads one edge before the offer is taken
        q_cfg = q;
        q_load = 1'h1;
        @(negedge core_clk_i);
        q_load = 1'h0;
        pipelined_i = pm;
        instr_i = d;
        instr_valid_i = 1'h1;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        instr_valid_i = 1'h0;
        check("ready", instr_ready_o, 1'h0);
        check("busy", busy_o, 1'h1);
        check("tdpr", tdpr_o, dp);
        check("exposed", exposed_o, ex);
        check("tfit", tfit_o, fi);
        check("stall", stall_o, st);
        check("te", te_o, te);
        check("teff", teff_o, te + d.t_dep + d.t_storage);
        check("break", break_o, k);
        n = 1;
        dc = 0;
        ac = (au_start_o === 1'h1) ? 1 : 0;
        while (instr_ready_o !== 1'h1 && n < 300) begin
            @(negedge core_clk_i);
            n++;
            if (au_start_o === 1'h1) ac = n;
            if (done_o === 1'h1) dc = n;
        end
        if (n >= 300) begin
            mismatches++;
            results();
        end
        check("idle_busy", busy_o, 1'h0);
        check("done", dc, st + (te > 1 ? te : 1) + 1);
        check("au_start", ac, dc + k);
        p_teu = d.execution_unit_time;
        p_tfit = fi;
        p_brk = brk;
        p_k = k;
    endtask : run

    // Break codes zero, positive, negative
    task automatic s_breaks;
        d = mk(0, 0);
        d.has_break = 1'h1;
        run(1'h0, '0);
        d = mk(5, 4);
        d.has_break = 1'h1;
        d.break_code = 8'sh03;
        d.t_dep = 8'h02;
        d.t_storage = 8'h01;
        run(1'h0, '0);
        d = mk(2, 9);
        d.is_float = 1'h1;
        d.float_mem_break = 1'h1;
        d.size = aut_pkg::aut_size_long;
        d.t_send = 8'h02;
        d.t_complete = 8'h05;
        d.t_fpu = 8'h04;
        run(1'h0, '0);
        d.size = aut_pkg::aut_size_std;
        d.address_unit_time = 8'h01;
        run(1'h0, '0);
    endtask : s_breaks

    // Write drain, locked access, then exposed and hidden time
    task automatic s_drain;
        d = mk(3, 6);
        d.wait_writes = 1'h1;
        d.second_operand = 1'h1;
        d.interlocked = 1'h1;
        run(1'h0, '0);
        d = mk(10, 3);
        d.wait_writes = 1'h1;
        run(1'h0, '0);
        d = mk(2, 2);
        run(1'h0, '0);
    endtask : s_drain

    // Pipelined queue waits and transfer groups
    task automatic s_pipe;
        d = mk(1, 2);
        run(1'h1, '{full: 1'h1, all_time: 8'h09, first_time: 8'h04});
        run(1'h0, '{full: 1'h1, all_time: 8'h09, first_time: 8'h04});
        d.is_float = 1'h1;
        d.t_send = 8'h02;
        d.t_complete = 8'h03;
        run(1'h1, '{full: 1'h1, all_time: 8'h09, first_time: 8'h04});
        d.group = aut_pkg::aut_group_b;
        run(1'h1, '{full: 1'h0, all_time: 8'h09, first_time: 8'h04});
        run(1'h1, '{full: 1'h0, all_time: 8'h01, first_time: 8'h01});
        d = mk(12, 2);
        run(1'h0, '0);
    endtask : s_pipe

    // All four branch outcomes
    task automatic s_branch;
        for (int b = 0; b < 4; b++) begin
            d = mk(2, 2);
            d.is_branch = 1'h1;
            d.branch = aut_pkg::aut_branch_type'(b);
            run(1'h0, '0);
        end
    endtask : s_branch

    // Main sequence
    initial begin
        arst_n_i = 1'h0;
        instr_valid_i = 1'h0;
        pipelined_i = 1'h0;
        q_load = 1'h0;
        q_cfg = '0;
        instr_i = '0;
        {mismatches, compares, p_teu, p_tfit, p_k} = '0;
        p_brk = 1'h0;
        repeat (2) @(negedge core_clk_i);
        arst_n_i = 1'h1;
        check("reset_ready", instr_ready_o, 1'h1);
        check("reset_busy", busy_o, 1'h0);
        s_breaks();
        s_drain();
        s_pipe();
        s_branch();
        results();
    end
endmodule : address_unit_issue_timing_tb_top
`default_nettype wire
